// >>> design/sppps_defs.svh
`ifndef SPPPS_DEFS_SVH
`define SPPPS_DEFS_SVH
// register byte offsets on the bus
`define SPPPS_ADDR_W         8
`define SPPPS_PIN_CONTROL    8'h00
`define SPPPS_PORT_CONTROL   8'h04
// pin_control field positions
`define SPPPS_TX_GPIO_EN     13
`define SPPPS_RX_GPIO_EN     12
`define SPPPS_DOUT_STAT      5
`define SPPPS_DIN_STAT       4
`define SPPPS_TX_FS_POL      3
`define SPPPS_RX_FS_POL      2
`define SPPPS_TX_CLK_POL     1
`define SPPPS_RX_CLK_POL     0
// port_control field positions
`define SPPPS_TX_RESET_N     0
`define SPPPS_RX_RESET_N     1
// reset values
`define SPPPS_PIN_CONTROL_RST  32'h0000_0000
`define SPPPS_PORT_CONTROL_RST 32'h0000_0000
// index of each synchronised pin
`define SPPPS_NPINS          5
`define SPPPS_P_TXCLK        0
`define SPPPS_P_RXCLK        1
`define SPPPS_P_TXFS         2
`define SPPPS_P_RXFS         3
`define SPPPS_P_DIN          4
`endif

// >>> design/sppps_pkg.sv
`default_nettype none
package sppps_pkg;
  // data phase of the bus slave, one-hot
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b001,
    PH_WRITE = 3'b010,
    PH_READ  = 3'b100
  } sppps_phase_type;
endpackage
`default_nettype wire

// >>> design/sppps_pin_if.sv
`timescale 1ns/1ns
`default_nettype none
// synchronised pin levels and their edges
interface sppps_pin_if #(parameter int N = 5);
  logic [N-1:0] lvl;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport front (output lvl, output rise, output fall);
  modport core  (input lvl, input rise, input fall);
endinterface
`default_nettype wire

// >>> design/sppps_pin_front.sv
`timescale 1ns/1ns
`default_nettype none
module sppps_pin_front #(
  parameter int N = 5
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // raw pins from outside the clock domain
  input  wire logic [N-1:0] raw,
  // synchronised view
  sppps_pin_if.front        pins
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      logic s1_r, s2_r, s3_r;
      logic s1_nxt, s2_nxt, s3_nxt;
      // two-stage synchroniser, third stage only for edge finding
      always_comb begin
        s1_nxt = raw[i];
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        if (rst) begin
          s1_nxt = 1'b0;
          s2_nxt = 1'b0;
          s3_nxt = 1'b0;
        end
      end
      always_ff @(posedge clk) begin
        s1_r <= s1_nxt;
        s2_r <= s2_nxt;
        s3_r <= s3_nxt;
      end
      // edges look only at settled stages, never at the first flop
      assign pins.lvl[i]  = s2_r;
      assign pins.rise[i] = s2_r & ~s3_r;
      assign pins.fall[i] = ~s2_r & s3_r;
    end
  endgenerate
endmodule
`default_nettype wire

// >>> design/sppps_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sppps_defs.svh"
// Operation
// - in gpio output mode the data-out status bit reports the driven pin level
// - in gpio input mode status bit 4 returns the sampled data-in pin level
// - bit 3 clear makes transmit frame sync active high, set active low
// - bit 2 clear makes receive frame sync active high, set active low
// - bit 1 picks transmit sampling edge: rising when clear, falling when set
// - bit 0 picks receive sampling edge: falling when clear, rising when set
// - data-out pin is gpio only with bit 13 set and transmitter in reset
// - data-in pin is gpio only with bit 12 set and receiver in reset
module sppps_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // serial pins
  input  wire logic        tx_bit_clock_pin,
  input  wire logic        rx_bit_clock_pin,
  input  wire logic        tx_frame_sync_pin,
  input  wire logic        rx_frame_sync_pin,
  input  wire logic        serial_data_in_pin,
  output logic             serial_data_out_pin,
  output logic             serial_data_out_oe,
  // data path side
  input  wire logic        tx_serial_data,
  output logic             tx_frame_sync_active,
  output logic             rx_frame_sync_active,
  output logic             tx_sample_strobe,
  output logic             rx_sample_strobe,
  output logic             rx_data_bit
);
  sppps_pin_if #(.N(`SPPPS_NPINS)) pins ();

  sppps_pin_front #(.N(`SPPPS_NPINS)) u_front (
    .clk  (clk),
    .rst  (rst),
    .raw  ({serial_data_in_pin, rx_frame_sync_pin, tx_frame_sync_pin,
            rx_bit_clock_pin, tx_bit_clock_pin}),
    .pins (pins)
  );

  // reset images of the two registers, fields are picked from these
  localparam logic [31:0] pc_rst   = `SPPPS_PIN_CONTROL_RST;
  localparam logic [31:0] port_rst = `SPPPS_PORT_CONTROL_RST;

  // control state
  logic                       txgpio_r, txgpio_nxt;
  logic                       rxgpio_r, rxgpio_nxt;
  logic                       dout_stat_r, dout_stat_nxt;
  logic                       din_stat_r, din_stat_nxt;
  logic [3:0]                 pol_r, pol_nxt;
  logic                       txrst_n_r, txrst_n_nxt;
  logic                       rxrst_n_r, rxrst_n_nxt;
  // bus state
  sppps_pkg::sppps_phase_type ph_r, ph_nxt;
  logic [`SPPPS_ADDR_W-1:0]   wa_r, wa_nxt;
  logic [31:0]                rd_r, rd_nxt;
  // pin-side state
  logic                       dout_r, dout_nxt;
  logic                       oe_r, oe_nxt;
  logic                       txfs_r, txfs_nxt;
  logic                       rxfs_r, rxfs_nxt;
  logic                       txs_r, txs_nxt;
  logic                       rxs_r, rxs_nxt;
  logic                       rxd_r, rxd_nxt;

  logic                       tx_gpio_act;
  logic                       rx_gpio_act;
  logic                       addr_ok;
  logic                       tx_take;
  logic                       tx_launch;
  logic                       rx_take;
  logic [31:0]                pc_view;
  logic [31:0]                port_view;

  // gpio modes need both the enable and the half held in reset
  // gpio output and input qualify
  assign tx_gpio_act = txgpio_r & ~txrst_n_r;
  assign rx_gpio_act = rxgpio_r & ~rxrst_n_r;

  assign addr_ok = hsel & hready & htrans[1];

  assign tx_take   = pol_r[`SPPPS_TX_CLK_POL] ? pins.fall[`SPPPS_P_TXCLK]
                                             : pins.rise[`SPPPS_P_TXCLK];
  // data changes on the edge opposite the partner's sampling edge
  assign tx_launch = pol_r[`SPPPS_TX_CLK_POL] ? pins.rise[`SPPPS_P_TXCLK]
                                             : pins.fall[`SPPPS_P_TXCLK];
  assign rx_take   = pol_r[`SPPPS_RX_CLK_POL] ? pins.rise[`SPPPS_P_RXCLK]
                                             : pins.fall[`SPPPS_P_RXCLK];

  // register writes land in the data phase
  always_comb begin
    txgpio_nxt    = txgpio_r;
    rxgpio_nxt    = rxgpio_r;
    dout_stat_nxt = dout_stat_r;
    pol_nxt       = pol_r;
    txrst_n_nxt   = txrst_n_r;
    rxrst_n_nxt   = rxrst_n_r;
    din_stat_nxt  = din_stat_r;
    if (ph_r == sppps_pkg::PH_WRITE) begin
      if (wa_r == `SPPPS_PIN_CONTROL) begin
        txgpio_nxt    = hwdata[`SPPPS_TX_GPIO_EN];
        rxgpio_nxt    = hwdata[`SPPPS_RX_GPIO_EN];
        dout_stat_nxt = hwdata[`SPPPS_DOUT_STAT];
        pol_nxt       = hwdata[3:0];
      end else if (wa_r == `SPPPS_PORT_CONTROL) begin
        txrst_n_nxt = hwdata[`SPPPS_TX_RESET_N];
        rxrst_n_nxt = hwdata[`SPPPS_RX_RESET_N];
      end
    end
    // track the data-in pin in gpio mode
    if (rx_gpio_act) begin
      din_stat_nxt = pins.lvl[`SPPPS_P_DIN];
    end
    if (rst) begin
      txgpio_nxt    = pc_rst[`SPPPS_TX_GPIO_EN];
      rxgpio_nxt    = pc_rst[`SPPPS_RX_GPIO_EN];
      dout_stat_nxt = pc_rst[`SPPPS_DOUT_STAT];
      din_stat_nxt  = pc_rst[`SPPPS_DIN_STAT];
      pol_nxt       = pc_rst[3:0];
      txrst_n_nxt   = port_rst[`SPPPS_TX_RESET_N];
      rxrst_n_nxt   = port_rst[`SPPPS_RX_RESET_N];
    end
  end
  always_ff @(posedge clk) begin
    txgpio_r    <= txgpio_nxt;
    rxgpio_r    <= rxgpio_nxt;
    dout_stat_r <= dout_stat_nxt;
    din_stat_r  <= din_stat_nxt;
    pol_r       <= pol_nxt;
    txrst_n_r   <= txrst_n_nxt;
    rxrst_n_r   <= rxrst_n_nxt;
  end

  // read views use next values so a read right after a write sees it
  // status shows the level on the output pin
  always_comb begin
    pc_view = 32'h0000_0000;
    pc_view[`SPPPS_TX_GPIO_EN] = txgpio_nxt;
    pc_view[`SPPPS_RX_GPIO_EN] = rxgpio_nxt;
    pc_view[`SPPPS_DOUT_STAT]  = dout_nxt;
    pc_view[`SPPPS_DIN_STAT]   = din_stat_nxt;
    pc_view[3:0]               = pol_nxt;
    port_view = 32'h0000_0000;
    port_view[`SPPPS_TX_RESET_N] = txrst_n_nxt;
    port_view[`SPPPS_RX_RESET_N] = rxrst_n_nxt;
  end

  // address phase capture; zero wait states, so hready is always high
  always_comb begin
    ph_nxt = sppps_pkg::PH_IDLE;
    wa_nxt = wa_r;
    rd_nxt = rd_r;
    if (addr_ok) begin
      wa_nxt = haddr[`SPPPS_ADDR_W-1:0];
      if (hwrite) begin
        ph_nxt = sppps_pkg::PH_WRITE;
      end else begin
        ph_nxt = sppps_pkg::PH_READ;
        if (haddr[`SPPPS_ADDR_W-1:0] == `SPPPS_PIN_CONTROL) begin
          rd_nxt = pc_view;
        end else if (haddr[`SPPPS_ADDR_W-1:0] == `SPPPS_PORT_CONTROL) begin
          rd_nxt = port_view;
        end else begin
          rd_nxt = 32'h0000_0000;  // unmapped reads as zero, still okay
        end
      end
    end
    if (rst) begin
      ph_nxt = sppps_pkg::PH_IDLE;
      wa_nxt = 8'h00;
      rd_nxt = 32'h0000_0000;
    end
  end
  always_ff @(posedge clk) begin
    ph_r <= ph_nxt;
    wa_r <= wa_nxt;
    rd_r <= rd_nxt;
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rd_r;

  // pin side: output pin, frame-sync decode, sampling strobes
  always_comb begin
    dout_nxt = dout_r;
    // software level drives the pin in gpio mode
    if (tx_gpio_act) begin
      dout_nxt = dout_stat_nxt;
    end else if (tx_launch) begin
      dout_nxt = tx_serial_data;
    end
    // pin stays undriven while the transmitter is held in reset and not in gpio mode
    oe_nxt   = tx_gpio_act | txrst_n_r;
    txfs_nxt = pins.lvl[`SPPPS_P_TXFS] ^ pol_r[`SPPPS_TX_FS_POL];
    rxfs_nxt = pins.lvl[`SPPPS_P_RXFS] ^ pol_r[`SPPPS_RX_FS_POL];
    txs_nxt  = tx_take & txrst_n_r;
    // serial receive only when the pin is not gpio
    rxs_nxt  = rx_take & rxrst_n_r & ~rx_gpio_act;
    rxd_nxt  = rxd_r;
    if (rx_take & rxrst_n_r) begin
      rxd_nxt = pins.lvl[`SPPPS_P_DIN];
    end
    if (rst) begin
      dout_nxt = 1'b0;
      oe_nxt   = 1'b0;
      txfs_nxt = 1'b0;
      rxfs_nxt = 1'b0;
      txs_nxt  = 1'b0;
      rxs_nxt  = 1'b0;
      rxd_nxt  = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    dout_r <= dout_nxt;
    oe_r   <= oe_nxt;
    txfs_r <= txfs_nxt;
    rxfs_r <= rxfs_nxt;
    txs_r  <= txs_nxt;
    rxs_r  <= rxs_nxt;
    rxd_r  <= rxd_nxt;
  end

  assign serial_data_out_pin  = dout_r;
  assign serial_data_out_oe   = oe_r;
  assign tx_frame_sync_active = txfs_r;
  assign rx_frame_sync_active = rxfs_r;
  assign tx_sample_strobe     = txs_r;
  assign rx_sample_strobe     = rxs_r;
  assign rx_data_bit          = rxd_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_txgpio_held;
    tx_gpio_act ##1 tx_gpio_act;
  endsequence
  sequence s_rxgpio_held;
    rx_gpio_act ##1 rx_gpio_act;
  endsequence

  dout_status_a: assert property (s_txgpio_held |-> serial_data_out_pin == dout_stat_r)
    else $error("data-out pin differs from its status bit in gpio mode");
  din_track_a: assert property (s_rxgpio_held |-> din_stat_r == $past(pins.lvl[4]))
    else $error("data-in status does not follow the pin");
  txfs_pol_a: assert property (1'b1 |=> tx_frame_sync_active
      == ($past(pins.lvl[2]) ^ $past(pol_r[3])))
    else $error("transmit frame sync polarity wrong");
  rxfs_pol_a: assert property (1'b1 |=> rx_frame_sync_active
      == ($past(pins.lvl[3]) ^ $past(pol_r[2])))
    else $error("receive frame sync polarity wrong");
  tx_edge_a: assert property (txrst_n_r && (pol_r[1] ? pins.fall[0] : pins.rise[0])
      |=> tx_sample_strobe)
    else $error("transmit sample strobe missing on chosen edge");
  rx_edge_a: assert property (rx_sample_strobe |-> ($past(pol_r[0]) ?
      $past(pins.rise[1]) : $past(pins.fall[1])))
    else $error("receive strobe on wrong edge");
  dout_oe_a: assert property (tx_gpio_act |=> serial_data_out_oe)
    else $error("data-out pin not driven in gpio mode");
  din_hold_a: assert property (!rx_gpio_act |=> $stable(din_stat_r))
    else $error("data-in status moved outside gpio mode");
  din_ro_a: assert property (ph_r == sppps_pkg::PH_WRITE |=> din_stat_r
      == ($past(rx_gpio_act) ? $past(pins.lvl[4]) : $past(din_stat_r)))
    else $error("bus write changed data-in status");
endmodule
`default_nettype wire

// >>> sim/sppps_codec.sv
`timescale 1ns/1ns
`default_nettype none
// codec on the far side; its bit clocks stay low outside frames
module sppps_codec (
  // link pins toward the device
  output logic     tx_bit_clock_pin,
  output logic     rx_bit_clock_pin,
  output logic     tx_frame_sync_pin,
  output logic     rx_frame_sync_pin,
  output logic     serial_data_in_pin,
  // device output
  input wire logic serial_data_out_pin
);
  logic [7:0] tx_seen;
  // static levels with bit clocks parked low; also gives the idle levels at time zero
  task automatic hold(input logic din, input logic tx_fs, input logic rx_fs);
    {tx_bit_clock_pin, rx_bit_clock_pin} = 2'h0;
    {serial_data_in_pin, tx_frame_sync_pin, rx_frame_sync_pin} = {din, tx_fs, rx_fs};
  endtask
  // one 8-bit frame on both links, pol = tx fs, rx fs, tx clock, rx clock polarities
  task automatic frame(input logic [7:0] b, input logic [3:0] pol);
    tx_frame_sync_pin = ~pol[3];
    rx_frame_sync_pin = ~pol[2];
    serial_data_in_pin = b[0];
    for (int k = 0; k < 8; k++) begin
      #62;
      {tx_bit_clock_pin, rx_bit_clock_pin} = 2'h3;
      if (!pol[1]) tx_seen[k] = serial_data_out_pin;
      if (!pol[0]) serial_data_in_pin = b[k];
      #63;
      {tx_bit_clock_pin, rx_bit_clock_pin} = 2'h0;
      if (pol[1]) tx_seen[k] = serial_data_out_pin;
      if (pol[0] && k < 7) serial_data_in_pin = b[k + 1];
    end
    #62;
    // released data line shows the inverse so a stale bit cannot pass
    serial_data_in_pin = ~serial_data_in_pin;
    tx_frame_sync_pin = pol[3];
    rx_frame_sync_pin = pol[2];
  endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic        tx_bit_clock_pin, rx_bit_clock_pin, tx_frame_sync_pin, rx_frame_sync_pin;
  logic        serial_data_in_pin, serial_data_out_pin, serial_data_out_oe, tx_serial_data;
  logic        tx_frame_sync_active, rx_frame_sync_active;
  logic        tx_sample_strobe, rx_sample_strobe, rx_data_bit;
  logic        tx_q[$];
  logic        rx_q[$];
  int          err_total;
  int          checked;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  sppps_top dut_u (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .tx_bit_clock_pin, .rx_bit_clock_pin, .tx_frame_sync_pin,
    .rx_frame_sync_pin, .serial_data_in_pin, .serial_data_out_pin, .serial_data_out_oe,
    .tx_serial_data, .tx_frame_sync_active, .rx_frame_sync_active, .tx_sample_strobe,
    .rx_sample_strobe, .rx_data_bit);

  sppps_codec codec_u (.tx_bit_clock_pin, .rx_bit_clock_pin, .tx_frame_sync_pin,
    .rx_frame_sync_pin, .serial_data_in_pin, .serial_data_out_pin);

  // xorshift source for all random stimulus
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected pin_control read: writable fields as written, bit 4 from the pin
  function automatic logic [31:0] exp_pc(input logic [31:0] w, input logic b4);
    return (w & 32'h0000_302F) | {27'h0, b4, 4'h0};
  endfunction

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single word transfer; waits on ready, never on a cycle count
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  task automatic finish_test();
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // new transmit bit after each sampling strobe; received bits are collected
  always @(posedge clk) begin
    logic [31:0] v;
    if (rst) begin
      tx_serial_data <= 1'b0;
    end else if (tx_sample_strobe === 1'b1) begin
      v = rnd();
      tx_serial_data <= v[9];
      tx_q.push_back(v[9]);
    end
    if (rx_sample_strobe === 1'b1) rx_q.push_back(rx_data_bit);
  end

  // watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial begin
    logic [31:0] w;
    logic        b4;
    {rst, hsel, hwrite, b4} = 4'h8;
    codec_u.hold(1'b0, 1'b0, 1'b0);
    {htrans, hsize, haddr, hwdata} = {2'h0, 3'h2, 64'h0};
    {err_total, checked} = 64'h0;
    seed = 32'h0001_32B1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 8'h00, 32'h0, rd);
    cmp("pin_control reset", 32'h0, rd);
    bus(1'b0, 8'h04, 32'h0, rd);
    cmp("port_control reset", 32'h0, rd);
    cmp("dout enable idle", 32'h0, {31'h0, serial_data_out_oe});
    bus(1'b1, 8'h08, rnd(), rd);
    bus(1'b0, 8'h08, 32'h0, rd);
    cmp("unmapped read", 32'h0, rd);
    // gpio mode with both sides in reset; sync latency is a few cycles
    for (int i = 0; i < 12; i++) begin
      w = rnd() | 32'h0000_2000;
      bus(1'b1, 8'h00, w, rd);
      codec_u.hold(w[16], w[17], w[18]);
      repeat (4) @(posedge clk);
      bus(1'b0, 8'h00, 32'h0, rd);
      if (w[12]) b4 = w[16];
      cmp("pin_control", exp_pc(w, b4), rd);
      cmp("dout pin", {31'h0, w[5]}, {31'h0, serial_data_out_pin});
      cmp("dout enable", 32'h1, {31'h0, serial_data_out_oe});
      cmp("tx fs active", {31'h0, w[17] ^ w[3]}, {31'h0, tx_frame_sync_active});
      cmp("rx fs active", {31'h0, w[18] ^ w[2]}, {31'h0, rx_frame_sync_active});
    end
    // serial frames in every polarity; gpio enables set but inactive out of reset
    bus(1'b1, 8'h04, 32'h3, rd);
    for (int p = 0; p < 16; p++) begin
      bus(1'b1, 8'h00, {18'h0, 2'h3, 8'h0, p[3:0]}, rd);
      w = rnd();
      tx_q.delete();
      rx_q.delete();
      tx_q.push_back(tx_serial_data);
      codec_u.frame(w[7:0], p[3:0]);
      cmp("rx bit count", 32'h8, rx_q.size());
      cmp("tx strobe count", 32'h9, tx_q.size());
      for (int k = 0; k < 8; k++) cmp("rx bit", {31'h0, w[k]}, {31'h0, rx_q[k]});
      for (int k = 1; k < 8; k++) cmp("tx bit", {31'h0, tx_q[k]}, {31'h0, codec_u.tx_seen[k]});
    end
    bus(1'b0, 8'h00, 32'h0, rd);
    cmp("din status held", {27'h0, b4, 4'h0}, rd & 32'h0000_0010);
    finish_test();
  end
endmodule
`default_nettype wire
